// ### rtl/idm_pkg.sv
// Shared constants and carriers for the IDE bus-master register bank
package idm_pkg;

  // Byte offsets inside the 16-byte IO window
  localparam logic [3:0]  OFS_PRI_CMD   = 4'h0;
  localparam logic [3:0]  OFS_PRI_STAT  = 4'h2;
  localparam logic [3:0]  OFS_PRI_BASE  = 4'h4;
  localparam logic [3:0]  OFS_SEC_CMD   = 4'h8;
  localparam logic [3:0]  OFS_SEC_STAT  = 4'hA;
  localparam logic [3:0]  OFS_SEC_BASE  = 4'hC;

  // Command register fields
  localparam int          CMD_START_BIT = 0;
  localparam int          CMD_DIR_BIT   = 3;

  // Status register fields
  localparam int          ST_ACTIVE_BIT  = 0;
  localparam int          ST_ERR_BIT     = 1;
  localparam int          ST_IRQ_BIT     = 2;
  localparam int          ST_CAP0_BIT    = 5;
  localparam int          ST_CAP1_BIT    = 6;
  localparam int          ST_SIMPLEX_BIT = 7;

  // Reset values
  localparam logic [7:0]  CMD_RESET     = 8'h00;
  localparam logic [7:0]  STAT_RESET    = 8'h00;
  localparam logic [31:0] BASE_RESET    = 32'h0000_0000;
  localparam logic [27:0] IO_BASE_RESET = 28'h000_0CC0;
  localparam logic [3:0]  IO_WIN_TAG    = 4'h1;

  // Descriptor layout: word 0 address, word 1 count and end-of-table flag
  localparam int          DESC_EOT_BIT  = 31;
  localparam int          DESC_CNT_W    = 16;
  localparam logic [31:0] DESC_STEP     = 32'h0000_0008;
  localparam logic [31:0] WORD_STEP     = 32'h0000_0004;

  // Memory request from a channel engine
  typedef struct packed {
    logic        req;
    logic        we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } idm_mem_req_s;

  // One data word with its valid flag
  typedef struct packed {
    logic        valid;
    logic [31:0] data;
  } idm_word_s;

endpackage

// ### rtl/idm_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/100ps
module idm_sync
  import idm_pkg::*;
#(
  parameter int WIDTH = 2
)(
  input  wire logic             clk_sys,
  input  wire logic             nrst,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  // First stage feeds only the second
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      stage1   <= '0;
      sync_out <= '0;
    end
    else if (ce)
    begin
      stage1   <= pin_in;
      sync_out <= stage1;
    end
  end

endmodule // idm_sync

// ### rtl/idm_chan.sv
// Descriptor-driven DMA engine for one channel
`timescale 1ns/100ps
module idm_chan
  import idm_pkg::*;
(
  input  wire logic         clk_sys,
  input  wire logic         nrst,
  input  wire logic         ce,
  input  wire logic         start,
  input  wire logic         dir,
  input  wire logic [29:0]  tbl_base,
  output logic              active,
  output logic              err_pulse,
  output idm_mem_req_s      mem,
  input  wire logic         mem_ack,
  input  wire logic         mem_err,
  input  wire logic [31:0]  mem_rdata,
  input  wire idm_word_s    drv_in,
  output logic              drv_in_ready,
  output idm_word_s         drv_out,
  input  wire logic         drv_out_ready
);

  typedef enum logic [2:0] {
    CH_IDLE      = 3'b000,
    CH_DESC_ADDR = 3'b001,
    CH_DESC_CNT  = 3'b010,
    CH_MEM       = 3'b011,
    CH_DRV       = 3'b100,
    CH_NEXT      = 3'b101
  } idm_chan_e;

  idm_chan_e   state;
  logic [31:0] desc_ptr;
  logic [31:0] buf_addr;
  logic [16:0] remain;
  logic        last;
  logic        dir_q;

  // Descriptor walk and word transfer
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      state        <= CH_IDLE;
      desc_ptr     <= '0;
      buf_addr     <= '0;
      remain       <= '0;
      last         <= 1'b0;
      dir_q        <= 1'b0;
      active       <= 1'b0;
      err_pulse    <= 1'b0;
      mem          <= '0;
      drv_in_ready <= 1'b0;
      drv_out      <= '0;
    end
    else if (ce)
    begin
      err_pulse <= 1'b0;
      unique case (state)
        CH_IDLE:
        begin
          if (start)
          begin
            active   <= 1'b1;
            dir_q    <= dir;
            desc_ptr <= {tbl_base, 2'b00};
            mem      <= '{req: 1'b1, we: 1'b0, addr: {tbl_base, 2'b00}, wdata: '0};
            state    <= CH_DESC_ADDR;
          end
        end
        CH_DESC_ADDR:
        begin
          if (mem_ack)
          begin
            buf_addr <= {mem_rdata[31:2], 2'b00};
            mem.addr <= desc_ptr + WORD_STEP;
            state    <= CH_DESC_CNT;
          end
        end
        CH_DESC_CNT:
        begin
          if (mem_ack)
          begin
            // A zero count stands for the full 64 KB region
            remain   <= (mem_rdata[DESC_CNT_W-1:0] == '0) ? 17'h1_0000
                        : {1'b0, mem_rdata[DESC_CNT_W-1:0]};
            last     <= mem_rdata[DESC_EOT_BIT];
            desc_ptr <= desc_ptr + DESC_STEP;
            if (dir_q)
            begin
              mem.req      <= 1'b0;
              drv_in_ready <= 1'b1;
              state        <= CH_DRV;
            end
            else
            begin
              mem.addr <= buf_addr;
              state    <= CH_MEM;
            end
          end
        end
        CH_MEM:
        begin
          if (mem_ack)
          begin
            mem.req <= 1'b0;
            if (dir_q)
              state <= CH_NEXT;
            else
            begin
              drv_out <= '{valid: 1'b1, data: mem_rdata};
              state   <= CH_DRV;
            end
          end
        end
        CH_DRV:
        begin
          if (dir_q && drv_in.valid)
          begin
            // Drive to memory: post the captured word
            drv_in_ready <= 1'b0;
            mem          <= '{req: 1'b1, we: 1'b1, addr: buf_addr, wdata: drv_in.data};
            state        <= CH_MEM;
          end
          else if (!dir_q && drv_out_ready)
          begin
            drv_out.valid <= 1'b0;
            state         <= CH_NEXT;
          end
        end
        CH_NEXT:
        begin
          buf_addr <= buf_addr + WORD_STEP;
          remain   <= remain - 17'(WORD_STEP);
          if (remain <= 17'(WORD_STEP) && last)
          begin
            active <= 1'b0;
            state  <= CH_IDLE;
          end
          else if (remain <= 17'(WORD_STEP))
          begin
            mem   <= '{req: 1'b1, we: 1'b0, addr: desc_ptr, wdata: '0};
            state <= CH_DESC_ADDR;
          end
          else if (dir_q)
          begin
            drv_in_ready <= 1'b1;
            state        <= CH_DRV;
          end
          else
          begin
            mem   <= '{req: 1'b1, we: 1'b0, addr: buf_addr + WORD_STEP, wdata: '0};
            state <= CH_MEM;
          end
        end
        default:
        begin
          state <= CH_IDLE;
        end
      endcase
      // Bus error ends the run at once
      if (mem_ack && mem_err && mem.req)
      begin
        err_pulse    <= 1'b1;
        active       <= 1'b0;
        mem.req      <= 1'b0;
        drv_in_ready <= 1'b0;
        drv_out      <= '0;
        state        <= CH_IDLE;
      end
    end
  end

  property p_err_stops;
    @(posedge clk_sys) disable iff (!nrst)
      err_pulse |-> (!active && !mem.req);
  endproperty
  a_err_stops: assert property (p_err_stops)
    else $error("engine still active after a bus error");

  property p_start_runs;
    @(posedge clk_sys) disable iff (!nrst)
      (ce && start && state == CH_IDLE) |=> (active && mem.req && !mem.we);
  endproperty
  a_start_runs: assert property (p_start_runs)
    else $error("start did not launch a descriptor fetch");

endmodule // idm_chan

// ### rtl/idm_regs.sv
// IDE bus-master register bank with two DMA channel engines
// What this block does
// - The bank answers IO accesses at offsets from the IO base held in the config register.
// - The IO base register selects a 16-byte window and its low four bits read 0001.
// - The bank lets software run DMA between drives and memory in the usual bus-master style.
// - Primary command bit 0 starts the engine on a write of one and always reads zero.
// - Primary command bit 3 is read-write and one means drive to memory.
// - Secondary command bit 0 starts the secondary engine on a write of one and reads zero.
// - Secondary command bit 3 is read-write and one means drive to memory.
// - Primary status bit 0 shows the engine active and bit 7 shows simplex, both read-only.
// - Secondary status bit 0 shows its engine active and bit 7 simplex, both read-only.
// - Status bit 1 is an error flag set by hardware and cleared by writing one.
// - Status bit 2 is set on a rising drive interrupt edge and cleared by writing one.
// - Status bits 5 and 6 are plain read-write drive DMA-capable flags.
// - The primary descriptor base stores bits 31 to 2 as a dword-aligned address.
// - Bits 1 and 0 of both descriptor bases always read zero.
// - The secondary descriptor base stores bits 31 to 2 read-write.
// - Reset clears the descriptor bases, sets command to 00h and status to 00h except bit 7, which shows SIMPLEX.
`timescale 1ns/100ps
module idm_regs
  import idm_pkg::*;
#(
  parameter int         NCH     = 2,
  parameter logic [1:0] SIMPLEX = 2'b00
)(
  input  wire logic                 clk_sys,
  input  wire logic                 nrst,
  input  wire logic                 ce,
  // Configuration access to the IO base register
  input  wire logic                 cfg_wr,
  input  wire logic [31:0]          cfg_wdata,
  output logic      [31:0]          cfg_rdata,
  // Host IO access
  input  wire logic                 io_rd,
  input  wire logic                 io_wr,
  input  wire logic [31:0]          io_addr,
  input  wire logic [3:0]           io_be,
  input  wire logic [31:0]          io_wdata,
  output logic      [31:0]          io_rdata,
  output logic                      io_ack,
  // Drive interrupt pins
  input  wire logic [NCH-1:0]       drv_irq,
  // Per-channel memory side
  output idm_mem_req_s [NCH-1:0]    mem_req,
  input  wire logic [NCH-1:0]       mem_ack,
  input  wire logic [NCH-1:0]       mem_err,
  input  wire logic [NCH-1:0][31:0] mem_rdata,
  // Per-channel drive data side
  input  wire idm_word_s [NCH-1:0]  drv_in,
  output logic      [NCH-1:0]       drv_in_ready,
  output idm_word_s [NCH-1:0]       drv_out,
  input  wire logic [NCH-1:0]       drv_out_ready
);

  logic [27:0]            io_base;
  logic                   hit;
  logic                   wr_hit;
  logic                   rd_hit;
  logic [NCH-1:0]         irq_sync;
  logic [NCH-1:0]         irq_prev;
  logic [NCH-1:0]         irq_rise;
  logic [NCH-1:0]         cmd_dir;
  logic [NCH-1:0]         stat_err;
  logic [NCH-1:0]         stat_irq;
  logic [NCH-1:0]         cap0;
  logic [NCH-1:0]         cap1;
  logic [NCH-1:0]         start;
  logic [NCH-1:0]         active;
  logic [NCH-1:0]         err_pulse;
  logic [NCH-1:0]         wr_cmd;
  logic [NCH-1:0]         wr_stat;
  logic [NCH-1:0][7:0]    cmd_byte;
  logic [NCH-1:0][7:0]    stat_byte;
  logic [NCH-1:0][29:0]   tbl_base;
  logic [NCH-1:0][31:0]   cmdstat_word;
  logic [NCH-1:0][31:0]   base_word;
  logic [NCH-1:0][31:0]   cmd_lane;
  logic [NCH-1:0][31:0]   stat_lane;
  logic [31:0]            next_rdata;

  // IO window decode against the configured base
  assign hit    = (io_addr[31:4] == io_base);
  assign wr_hit = io_wr && hit;
  assign rd_hit = io_rd && hit;

  // IO base register, low nibble fixed
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      io_base <= IO_BASE_RESET;
    else if (ce && cfg_wr)
      io_base <= cfg_wdata[31:4];
  end

  // Config readback
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      cfg_rdata <= {IO_BASE_RESET, IO_WIN_TAG};
    else if (ce)
      cfg_rdata <= {io_base, IO_WIN_TAG};
  end

  // Drive interrupt pins into the clock domain
  idm_sync #(
    .WIDTH    (NCH)
  ) u_irq_sync (
    .clk_sys  (clk_sys),
    .nrst     (nrst),
    .ce       (ce),
    .pin_in   (drv_irq),
    .sync_out (irq_sync)
  );

  // Previous interrupt level for edge detection
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      irq_prev <= '0;
    else if (ce)
      irq_prev <= irq_sync;
  end

  assign irq_rise = irq_sync & ~irq_prev;

  genvar c;
  generate
    for (c = 0; c < NCH; c++)
    begin : g_ch
      localparam logic [3:0] OFS_CMD  = (c == 0) ? OFS_PRI_CMD  : OFS_SEC_CMD;
      localparam logic [3:0] OFS_STAT = (c == 0) ? OFS_PRI_STAT : OFS_SEC_STAT;
      localparam logic [3:0] OFS_BASE = (c == 0) ? OFS_PRI_BASE : OFS_SEC_BASE;
      localparam int         LN_CMD   = int'(OFS_CMD[1:0]);
      localparam int         LN_STAT  = int'(OFS_STAT[1:0]);

      logic [7:0] cmd_wd;
      logic [7:0] stat_wd;

      assign cmd_wd  = io_wdata[8*LN_CMD +: 8];
      assign stat_wd = io_wdata[8*LN_STAT +: 8];

      // Byte-lane write strobes
      assign wr_cmd[c]  = wr_hit && ({io_addr[3:2], 2'b00} == {OFS_CMD[3:2], 2'b00})
                          && io_be[LN_CMD];
      assign wr_stat[c] = wr_hit && ({io_addr[3:2], 2'b00} == {OFS_STAT[3:2], 2'b00})
                          && io_be[LN_STAT];

      // Start is a write of one, never stored
      assign start[c] = ce && wr_cmd[c] && cmd_wd[CMD_START_BIT];

      // Direction bit
      always_ff @(posedge clk_sys or negedge nrst)
      begin
        if (!nrst)
          cmd_dir[c] <= CMD_RESET[CMD_DIR_BIT];
        else if (ce && wr_cmd[c])
          cmd_dir[c] <= cmd_wd[CMD_DIR_BIT];
      end

      // Error flag, hardware set beats software clear
      always_ff @(posedge clk_sys or negedge nrst)
      begin
        if (!nrst)
          stat_err[c] <= STAT_RESET[ST_ERR_BIT];
        else if (ce && err_pulse[c])
          stat_err[c] <= 1'b1;
        else if (ce && wr_stat[c] && stat_wd[ST_ERR_BIT])
          stat_err[c] <= 1'b0;
      end

      // Interrupt flag, edge set beats software clear
      always_ff @(posedge clk_sys or negedge nrst)
      begin
        if (!nrst)
          stat_irq[c] <= STAT_RESET[ST_IRQ_BIT];
        else if (ce && irq_rise[c])
          stat_irq[c] <= 1'b1;
        else if (ce && wr_stat[c] && stat_wd[ST_IRQ_BIT])
          stat_irq[c] <= 1'b0;
      end

      // Drive DMA-capable flags
      always_ff @(posedge clk_sys or negedge nrst)
      begin
        if (!nrst)
        begin
          cap0[c] <= STAT_RESET[ST_CAP0_BIT];
          cap1[c] <= STAT_RESET[ST_CAP1_BIT];
        end
        else if (ce && wr_stat[c])
        begin
          cap0[c] <= stat_wd[ST_CAP0_BIT];
          cap1[c] <= stat_wd[ST_CAP1_BIT];
        end
      end

      // Descriptor table base, per byte lane
      for (genvar b = 0; b < 4; b++)
      begin : g_lane
        localparam int LO = (b == 0) ? 2 : 8*b;
        always_ff @(posedge clk_sys or negedge nrst)
        begin
          if (!nrst)
            tbl_base[c][8*b+5 : LO-2] <= BASE_RESET[8*b+7 : LO];
          else if (ce && wr_hit && io_be[b]
                   && ({io_addr[3:2], 2'b00} == OFS_BASE))
            tbl_base[c][8*b+5 : LO-2] <= io_wdata[8*b+7 : LO];
        end
      end

      // Readback images
      assign cmd_byte[c]  = {4'h0, cmd_dir[c], 3'b000};
      assign stat_byte[c] = {SIMPLEX[c], cap1[c], cap0[c], 2'b00,
                             stat_irq[c], stat_err[c], active[c]};
      assign cmd_lane[c]     = 32'(cmd_byte[c]) << (8*LN_CMD);
      assign stat_lane[c]    = 32'(stat_byte[c]) << (8*LN_STAT);
      assign cmdstat_word[c] = cmd_lane[c] | stat_lane[c];
      assign base_word[c]    = {tbl_base[c], 2'b00};

      // Channel engine
      idm_chan u_chan (
        .clk_sys       (clk_sys),
        .nrst          (nrst),
        .ce            (ce),
        .start         (start[c]),
        .dir           (cmd_dir[c]),
        .tbl_base      (tbl_base[c]),
        .active        (active[c]),
        .err_pulse     (err_pulse[c]),
        .mem           (mem_req[c]),
        .mem_ack       (mem_ack[c]),
        .mem_err       (mem_err[c]),
        .mem_rdata     (mem_rdata[c]),
        .drv_in        (drv_in[c]),
        .drv_in_ready  (drv_in_ready[c]),
        .drv_out       (drv_out[c]),
        .drv_out_ready (drv_out_ready[c])
      );
    end
  endgenerate

  // Read data select by dword
  always_comb
  begin
    next_rdata = '0;
    for (int i = 0; i < NCH; i++)
    begin
      if (io_addr[3:2] == (i == 0 ? OFS_PRI_CMD[3:2] : OFS_SEC_CMD[3:2]))
        next_rdata = cmdstat_word[i];
      if (io_addr[3:2] == (i == 0 ? OFS_PRI_BASE[3:2] : OFS_SEC_BASE[3:2]))
        next_rdata = base_word[i];
    end
  end

  // Registered IO answer, zero outside the window
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      io_rdata <= '0;
      io_ack   <= 1'b0;
    end
    else if (ce)
    begin
      io_ack   <= rd_hit || wr_hit;
      io_rdata <= rd_hit ? next_rdata : '0;
    end
  end

  property p_cfg_tag;
    @(posedge clk_sys) disable iff (!nrst)
      cfg_rdata[3:0] == IO_WIN_TAG;
  endproperty
  a_cfg_tag: assert property (p_cfg_tag)
    else $error("IO base low nibble not fixed");

  property p_pri_start_zero;
    @(posedge clk_sys) disable iff (!nrst)
      (ce && rd_hit && io_addr[3:2] == OFS_PRI_CMD[3:2]) |=> (io_rdata[CMD_START_BIT] == 1'b0);
  endproperty
  a_pri_start_zero: assert property (p_pri_start_zero)
    else $error("primary start bit read back as one");

  property p_sec_start_zero;
    @(posedge clk_sys) disable iff (!nrst)
      (ce && rd_hit && io_addr[3:2] == OFS_SEC_CMD[3:2]) |=> (io_rdata[CMD_START_BIT] == 1'b0);
  endproperty
  a_sec_start_zero: assert property (p_sec_start_zero)
    else $error("secondary start bit read back as one");

  property p_dir_stored;
    @(posedge clk_sys) disable iff (!nrst)
      (ce && wr_cmd[0]) |=> (cmd_dir[0] == $past(io_wdata[CMD_DIR_BIT]));
  endproperty
  a_dir_stored: assert property (p_dir_stored)
    else $error("direction bit not stored");

  property p_active_read;
    @(posedge clk_sys) disable iff (!nrst)
      (ce && rd_hit && io_addr[3:2] == OFS_PRI_STAT[3:2])
        |=> (io_rdata[16+ST_ACTIVE_BIT] == $past(active[0]));
  endproperty
  a_active_read: assert property (p_active_read)
    else $error("active bit readback mismatch");

  property p_err_set;
    @(posedge clk_sys) disable iff (!nrst)
      (ce && err_pulse[1]) |=> stat_err[1];
  endproperty
  a_err_set: assert property (p_err_set)
    else $error("error flag not set by engine error");

  property p_irq_edge;
    @(posedge clk_sys) disable iff (!nrst)
      (ce && $rose(irq_sync[0])) |=> stat_irq[0];
  endproperty
  a_irq_edge: assert property (p_irq_edge)
    else $error("interrupt edge lost");

  property p_irq_hold;
    @(posedge clk_sys) disable iff (!nrst)
      (stat_irq[0] && !(wr_stat[0] && io_wdata[16+ST_IRQ_BIT])) |=> stat_irq[0];
  endproperty
  a_irq_hold: assert property (p_irq_hold)
    else $error("interrupt flag cleared without a write of one");

  property p_cap_write;
    @(posedge clk_sys) disable iff (!nrst)
      (ce && wr_stat[0]) |=> (cap1[0] == $past(io_wdata[16+ST_CAP1_BIT]));
  endproperty
  a_cap_write: assert property (p_cap_write)
    else $error("drive 1 capable flag not stored");

  property p_base_low_zero;
    @(posedge clk_sys) disable iff (!nrst)
      (ce && rd_hit && io_addr[2]) |=> (io_rdata[1:0] == 2'b00);
  endproperty
  a_base_low_zero: assert property (p_base_low_zero)
    else $error("descriptor base low bits not zero");

endmodule // idm_regs

// ### bench/idm_regs_bench.sv
// Self-checking bench for the IDE bus-master register bank
`timescale 1ns/100ps
module idm_regs_bench
  import idm_pkg::*;
;
  logic              clk_sys = 1'b0;
  logic              nrst    = 1'b0;
  logic              cfg_wr  = 1'b0;
  logic [31:0]       cfg_wdata = 32'h0000_0000;
  logic [31:0]       cfg_rdata;
  logic              io_rd   = 1'b0;
  logic              io_wr   = 1'b0;
  logic [31:0]       io_addr = 32'h0000_0000;
  logic [3:0]        io_be   = 4'h0;
  logic [31:0]       io_wdata = 32'h0000_0000;
  logic [31:0]       io_rdata;
  logic              io_ack;
  logic [1:0]        drv_irq = 2'b00;
  idm_mem_req_s [1:0] mem_req;
  logic [1:0]        mem_ack = 2'b00;
  logic              resp_en = 1'b0;
  logic [1:0]        mem_fail = 2'b11;
  logic [1:0][31:0]  mem_data = '0;
  logic [1:0][31:0]  got_word = '0;
  idm_word_s [1:0]   drv_out;
  logic [1:0]        drv_in_ready;
  int                err_total = 0;
  int                total_checks = 0;
  logic [31:0]       base;

  // 250 MHz system clock
  always #2 clk_sys = ~clk_sys;

  idm_regs dut (
    .clk_sys(clk_sys), .nrst(nrst), .ce(1'b1),
    .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .io_rd(io_rd), .io_wr(io_wr), .io_addr(io_addr), .io_be(io_be),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .io_ack(io_ack),
    .drv_irq(drv_irq), .mem_req(mem_req), .mem_ack(mem_ack),
    .mem_err(mem_fail), .mem_rdata(mem_data),
    .drv_in({2{33'h0_0000_0000}}), .drv_in_ready(drv_in_ready),
    .drv_out(drv_out), .drv_out_ready(2'b11)
  );

  // Memory side: count word 4 bytes with end flag, other words address plus 1000h
  always @(posedge clk_sys)
  begin
    for (int i = 0; i < 2; i++)
    begin
      mem_ack[i]  <= resp_en & mem_req[i].req & ~mem_ack[i];
      mem_data[i] <= mem_req[i].addr[2] ? 32'h8000_0004 : mem_req[i].addr + 32'h0000_1000;
      if (drv_out[i].valid)
        got_word[i] <= drv_out[i].data;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One IO access: strobe for one cycle, answer sampled one edge later
  task automatic acc(input logic w, input logic [31:0] a, input logic [3:0] be,
                     input logic [31:0] d, output logic [31:0] q, output logic k);
    @(posedge clk_sys);
    io_rd    <= ~w;
    io_wr    <= w;
    io_addr  <= a;
    io_be    <= be;
    io_wdata <= d;
    @(posedge clk_sys);
    io_rd <= 1'b0;
    io_wr <= 1'b0;
    #1;
    q = io_rdata;
    k = io_ack;
  endtask

  task automatic wr(input logic [31:0] a, input logic [3:0] be, input logic [31:0] d);
    logic [31:0] q;
    logic        k;
    acc(1'b1, a, be, d, q, k);
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic ka);
    logic [31:0] q;
    logic        k;
    acc(1'b0, a, 4'hF, 32'h0000_0000, q, k);
    chk(q, e);
    chk({31'h0000_0000, k}, {31'h0000_0000, ka});
  endtask

  task automatic end_of_test;
    $display("checks=%0d errors=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Watchdog against a hung handshake
  initial
  begin
    #20000;
    err_total++;
    end_of_test();
  end

  // Main sequence
  initial
  begin
    repeat (12) @(posedge clk_sys);
    nrst <= 1'b1;
    #1;
    chk(cfg_rdata, 32'h0000_CC01);
    for (int i = 0; i < 4; i++)
      rd(32'h0000_CC00 + 4 * i, 32'h0000_0000, 1'b1);
    for (int ch = 0; ch < 2; ch++)
    begin
      base = 32'h0000_CC00 + 8 * ch;
      wr(base + 4, 4'hF, 32'h0000_1003);
      rd(base + 4, 32'h0000_1000, 1'b1);
      // Read-only active and simplex ignore writes
      wr(base, 4'h5, 32'h00E1_0008);
      rd(base, 32'h0060_0008, 1'b1);
      resp_en <= 1'b0;
      wr(base, 4'h1, 32'h0000_0001);
      rd(base, 32'h0061_0000, 1'b1);
      chk(mem_req[ch].addr, 32'h0000_1000);
      chk({31'h0000_0000, mem_req[ch].req}, 32'h0000_0001);
      resp_en <= 1'b1;
      drv_irq[ch] <= 1'b1;
      repeat (10) @(posedge clk_sys);
      rd(base, 32'h0066_0000, 1'b1);
      wr(base, 4'h4, 32'h0060_0000);
      rd(base, 32'h0066_0000, 1'b1);
      // Pin still high: only a new rising edge may set it again
      wr(base, 4'h4, 32'h0066_0000);
      repeat (6) @(posedge clk_sys);
      rd(base, 32'h0060_0000, 1'b1);
      drv_irq[ch] <= 1'b0;
    end
    // One-word table on the primary channel, memory to drive, no bus error
    mem_fail <= 2'b00;
    wr(32'h0000_CC00, 4'h1, 32'h0000_0001);
    repeat (12) @(posedge clk_sys);
    chk(got_word[0], 32'h0000_3000);
    rd(32'h0000_CC00, 32'h0060_0000, 1'b1);
    rd(32'h0000_CD04, 32'h0000_0000, 1'b0);
    @(posedge clk_sys);
    cfg_wr    <= 1'b1;
    cfg_wdata <= 32'h0000_AB0F;
    @(posedge clk_sys);
    cfg_wr <= 1'b0;
    @(posedge clk_sys);
    #1;
    chk(cfg_rdata, 32'h0000_AB01);
    rd(32'h0000_AB0C, 32'h0000_1000, 1'b1);
    rd(32'h0000_CC0C, 32'h0000_0000, 1'b0);
    end_of_test();
  end
endmodule // idm_regs_bench
